//--- pkg/cmt_defines.svh
`ifndef CMT_DEFINES_SVH
`define CMT_DEFINES_SVH

// counter and prescaler width
`define CMT_WIDTH       32
// number of capture channels and match registers
`define CMT_NUM_CAP     2
`define CMT_NUM_MATCH   4
// number of match channels that may issue dma requests
`define CMT_NUM_DMA     2
// external match output actions
`define CMT_EMC_NONE    2'h0
`define CMT_EMC_LOW     2'h1
`define CMT_EMC_HIGH    2'h2
`define CMT_EMC_TOGGLE  2'h3
// capture edge select bit positions
`define CMT_CAP_RISE    0
`define CMT_CAP_FALL    1
// zero and one values for counters
`define CMT_ZERO        32'h0000_0000
`define CMT_ONE         32'h0000_0001

`endif

//--- pkg/cmt_pkg.sv
package cmt_pkg;
  // per match channel control
  typedef struct packed {
    logic       int_en;
    logic       reset_en;
    logic       stop_en;
    logic [1:0] ext_action;
  } cmt_match_ctl_type;

  // per capture channel control
  typedef struct packed {
    logic       int_en;
    logic [1:0] edge_sel;
  } cmt_cap_ctl_type;

  // counter mode selection
  typedef enum logic [1:0] {
    CMT_MODE_TIMER,
    CMT_MODE_CNT_RISE,
    CMT_MODE_CNT_FALL,
    CMT_MODE_CNT_BOTH
  } cmt_mode_type;
endpackage

//--- core/cmt_timer.sv
`timescale 1ns/1ps
`include "cmt_defines.svh"
// Function
// - 32-bit counter advanced through 32-bit prescaler
// - select internal clock timer or external counter
// - two capture channels latch counter on edge
// - per-channel optional capture interrupt
// - four match registers, optional interrupt, continue
// - match may stop counter and prescaler
// - match may reset counter to zero
// - match outputs: low, high, toggle, nothing
// - two match channels issue dma requests
module cmt_timer
  import cmt_pkg::*;
#(
  parameter int WIDTH = `CMT_WIDTH,
  parameter int NCAP  = `CMT_NUM_CAP,
  parameter int NMAT  = `CMT_NUM_MATCH,
  parameter int NDMA  = `CMT_NUM_DMA
) (
  input  wire logic                   mclk,
  input  wire logic                   resetn,
  input  wire logic                   cnt_enable,
  input  wire logic                   cnt_reset,
  input  wire cmt_mode_type           mode,
  input  wire logic [WIDTH-1:0]       prescale,
  input  wire logic [NMAT*WIDTH-1:0]  match_val,
  input  wire cmt_match_ctl_type [NMAT-1:0] match_ctl,
  input  wire cmt_cap_ctl_type [NCAP-1:0]   cap_ctl,
  input  wire logic [NMAT-1:0]        ext_init,
  input  wire logic                   ext_init_load,
  input  wire logic [NMAT+NCAP-1:0]   irq_clear,
  input  wire logic                   count_pin,
  input  wire logic [NCAP-1:0]        cap_pin,
  output logic [WIDTH-1:0]            count,
  output logic [WIDTH-1:0]            pre_count,
  output logic [NCAP*WIDTH-1:0]       cap_val,
  output logic [NMAT-1:0]             match_out,
  output logic [NMAT+NCAP-1:0]        irq_flags,
  output logic                        irq,
  output logic [NDMA-1:0]             dma_req,
  output logic                        running
);

  // pin synchronisers and previous levels
  logic [NCAP:0] pin_s1;
  logic [NCAP:0] pin_s2;
  logic [NCAP:0] pin_prev;
  logic          stopped;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pin_s1   <= '0;
      pin_s2   <= '0;
      pin_prev <= '0;
    end else begin
      pin_s1   <= {count_pin, cap_pin};
      pin_s2   <= pin_s1;
      pin_prev <= pin_s2;
    end
  end

  // edge detection on synchronised pins
  wire [NCAP:0] rise = pin_s2 & ~pin_prev;
  wire [NCAP:0] fall = ~pin_s2 & pin_prev;

  // count source selection
  logic cnt_tick;
  always_comb begin
    case (mode)
      CMT_MODE_TIMER:    cnt_tick = 1'b1;
      CMT_MODE_CNT_RISE: cnt_tick = rise[NCAP];
      CMT_MODE_CNT_FALL: cnt_tick = fall[NCAP];
      CMT_MODE_CNT_BOTH: cnt_tick = rise[NCAP] | fall[NCAP];
      default:           cnt_tick = 1'b0;
    endcase
  end

  // prescaler wrap advances the main counter
  wire active   = cnt_enable & ~stopped & ~cnt_reset;
  wire pre_wrap = active & cnt_tick & (pre_count == prescale);
  wire [WIDTH-1:0] count_inc = count + WIDTH'(1);

  // match detection on current count
  logic [NMAT-1:0] hit;
  always_comb begin
    for (int i = 0; i < NMAT; i++)
      hit[i] = pre_wrap & (count == match_val[i*WIDTH +: WIDTH]);
  end

  logic [NMAT-1:0] hit_rst;
  logic [NMAT-1:0] hit_stop;
  logic [NMAT-1:0] hit_int;
  always_comb begin
    for (int i = 0; i < NMAT; i++) begin
      hit_rst[i]  = hit[i] & match_ctl[i].reset_en;
      hit_stop[i] = hit[i] & match_ctl[i].stop_en;
      hit_int[i]  = hit[i] & match_ctl[i].int_en;
    end
  end

  // capture events
  logic [NCAP-1:0] cap_evt;
  always_comb begin
    for (int c = 0; c < NCAP; c++)
      cap_evt[c] = (rise[c] & cap_ctl[c].edge_sel[`CMT_CAP_RISE])
                 | (fall[c] & cap_ctl[c].edge_sel[`CMT_CAP_FALL]);
  end

  // prescaler and counter
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pre_count <= `CMT_ZERO;
      count     <= `CMT_ZERO;
    end else if (cnt_reset) begin
      pre_count <= `CMT_ZERO;
      count     <= `CMT_ZERO;
    end else if (pre_wrap) begin
      pre_count <= `CMT_ZERO;
      count     <= (|hit_rst) ? `CMT_ZERO : count_inc;
    end else if (active & cnt_tick) begin
      pre_count <= pre_count + WIDTH'(1);
    end
  end

  // stop on match holds counter and prescaler
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn)
      stopped <= 1'b0;
    else if (|hit_stop)
      stopped <= 1'b1;
    else if (!cnt_enable)
      stopped <= 1'b0;
  end
  assign running = cnt_enable & ~stopped;

  // capture registers
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cap_val <= '0;
    end else begin
      for (int c = 0; c < NCAP; c++)
        if (cap_evt[c])
          cap_val[c*WIDTH +: WIDTH] <= count;
    end
  end

  // sticky interrupt flags, set beats clear
  wire [NMAT+NCAP-1:0] flag_set;
  logic [NCAP-1:0] cap_int;
  always_comb begin
    for (int c = 0; c < NCAP; c++)
      cap_int[c] = cap_evt[c] & cap_ctl[c].int_en;
  end
  assign flag_set = {cap_int, hit_int};
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn)
      irq_flags <= '0;
    else
      irq_flags <= flag_set | (irq_flags & ~irq_clear);
  end
  assign irq = |irq_flags;

  // external match outputs
  logic [NMAT-1:0] next_match_out;
  always_comb begin
    for (int i = 0; i < NMAT; i++) begin
      next_match_out[i] = match_out[i];
      if (hit[i]) begin
        case (match_ctl[i].ext_action)
          `CMT_EMC_LOW:    next_match_out[i] = 1'b0;
          `CMT_EMC_HIGH:   next_match_out[i] = 1'b1;
          `CMT_EMC_TOGGLE: next_match_out[i] = ~match_out[i];
          default:         next_match_out[i] = match_out[i];
        endcase
      end
    end
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn)
      match_out <= '0;
    else if (ext_init_load)
      match_out <= ext_init;
    else
      match_out <= next_match_out;
  end

  // one-cycle dma request pulses from the low match channels
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn)
      dma_req <= '0;
    else
      dma_req <= hit[NDMA-1:0];
  end

  // assertions
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);

  pre_wrap_a: assert property (pre_wrap && !(|hit_rst) && !cnt_reset
      |=> count == $past(count) + 1) else $error("counter did not advance");
  pre_hold_a: assert property (!pre_wrap && !cnt_reset |=> count == $past(count))
      else $error("counter moved without prescaler wrap");
  timer_mode_a: assert property (mode == CMT_MODE_TIMER && active && !pre_wrap
      |=> pre_count == $past(pre_count) + 1) else $error("prescaler stuck");
  cap_load_a: assert property (cap_evt[0] |=> cap_val[WIDTH-1:0] == $past(count))
      else $error("capture 0 missed");
  cap_irq_a: assert property (cap_evt[0] && cap_ctl[0].int_en |=> irq_flags[NMAT])
      else $error("capture flag not set");
  match_irq_a: assert property (hit_int[0] |=> irq_flags[0] && irq)
      else $error("match flag not set");
  stop_hold_a: assert property ((|hit_stop) && cnt_enable |=> !running ##1 !running)
      else $error("stop on match failed");
  reset_zero_a: assert property ((|hit_rst) && !cnt_reset |=> count == `CMT_ZERO)
      else $error("reset on match failed");
  toggle_out_a: assert property (hit[0] && match_ctl[0].ext_action == `CMT_EMC_TOGGLE
      && !ext_init_load |=> match_out[0] != $past(match_out[0]))
      else $error("toggle output failed");
  dma_pulse_a: assert property (hit[0] |=> dma_req[0]) else $error("dma request missing");
  flag_stick_a: assert property (irq_flags[0] && !irq_clear[0] |=> irq_flags[0])
      else $error("flag dropped");

  wrap_c:  cover property (hit_rst[0]);
  stop_c:  cover property (hit_stop[1]);
  cap_c:   cover property (cap_evt[1]);
  count_c: cover property (mode == CMT_MODE_CNT_RISE && pre_wrap);

endmodule

//--- bench/cmt_pins_model.sv
`timescale 1ns/1ps
// far-side pins: count input and capture inputs
module cmt_pins_model (
  input  wire logic       mclk,
  output logic            count_pin,
  output logic [1:0]      cap_pin
);
  initial begin
    count_pin = 1'b0;
    cap_pin   = 2'b00;
  end
  // n slow count pulses, high held 4 cycles, low held 5 cycles between pulses
  task automatic pulse_count(input int n);
    repeat (n) begin
      @(posedge mclk) count_pin <= 1'b1;
      repeat (4) @(posedge mclk);
      count_pin <= 1'b0;
      repeat (4) @(posedge mclk);
    end
  endtask
  // one transition on a capture pin, then settle time
  task automatic edge_cap(input int ch);
    @(posedge mclk) cap_pin[ch] <= ~cap_pin[ch];
    repeat (6) @(posedge mclk);
  endtask
endmodule

//--- bench/tb_capture_match_timer.sv
`timescale 1ns/1ps
`define CMP(a, e) begin comparisons++; if ((a) !== (e)) begin bad_count++; $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, a, e); end end
module tb_capture_match_timer;
  import cmt_pkg::*;
  logic mclk = 0, resetn = 0, cnt_enable = 0, cnt_reset = 0, ext_init_load = 0;
  logic count_pin;
  logic [1:0] cap_pin, dma_req;
  cmt_mode_type mode = CMT_MODE_TIMER;
  logic [31:0] prescale = '0, count, pre_count;
  logic [127:0] match_val = '0;
  cmt_match_ctl_type [3:0] match_ctl = '0;
  cmt_cap_ctl_type [1:0] cap_ctl = '0;
  logic [3:0] ext_init = '0, match_out;
  logic [5:0] irq_clear = '0, irq_flags;
  logic [63:0] cap_val;
  logic irq, running;
  int bad_count = 0, comparisons = 0;
  // 10 MHz clock
  initial forever #50 mclk = ~mclk;
  cmt_pins_model cmt_pins_model_i (.mclk(mclk), .count_pin(count_pin), .cap_pin(cap_pin));
  cmt_timer cmt_timer_i (.mclk(mclk), .resetn(resetn), .cnt_enable(cnt_enable),
    .cnt_reset(cnt_reset), .mode(mode), .prescale(prescale), .match_val(match_val),
    .match_ctl(match_ctl), .cap_ctl(cap_ctl), .ext_init(ext_init),
    .ext_init_load(ext_init_load), .irq_clear(irq_clear), .count_pin(count_pin),
    .cap_pin(cap_pin), .count(count), .pre_count(pre_count), .cap_val(cap_val),
    .match_out(match_out), .irq_flags(irq_flags), .irq(irq), .dma_req(dma_req),
    .running(running));
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // reset held 6 cycles, then enable counting
  task automatic restart;
    @(posedge mclk) resetn <= 1'b0;
    cnt_enable <= 1'b0;
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk) cnt_enable <= 1'b1;
  endtask
  // bounded wait for an interrupt flag
  task automatic wait_flag(input int idx);
    for (int i = 0; i <= 60; i++) begin
      @(posedge mclk) #1;
      if (irq_flags[idx] === 1'b1) return;
    end
    bad_count++;
    complete_run;
  endtask
  // prescaler divides by value plus one
  task automatic test_prescale;
    prescale <= 32'h0000_0003;
    restart;
    repeat (12) @(posedge mclk);
    #1 `CMP(count, 32'h0000_0003)
    `CMP(pre_count, 32'h0000_0000)
    $display("test prescale done");
  endtask
  // reset on match, toggle output, dma pulse, sticky flag
  task automatic test_reset_match;
    prescale <= '0;
    match_val <= {96'h0, 32'h0000_0005};
    match_ctl[0] <= '{1'b1, 1'b1, 1'b0, 2'h3};
    restart;
    wait_flag(0);
    `CMP(count, 32'h0000_0000)
    `CMP({dma_req, match_out}, 6'h11)
    @(posedge mclk) irq_clear <= 6'h01;
    @(posedge mclk) irq_clear <= 6'h00;
    #1 `CMP({irq, irq_flags}, 7'h00)
    $display("test reset match done");
  endtask
  // all four output actions at one match, one channel stops
  task automatic test_stop_actions;
    logic [31:0] held;
    match_val <= {4{32'h0000_0007}};
    match_ctl <= {{5'b00011}, {5'b10010}, {5'b00101}, {5'b00000}};
    ext_init <= 4'h5;
    restart;
    @(posedge mclk) ext_init_load <= 1'b1;
    @(posedge mclk) ext_init_load <= 1'b0;
    wait_flag(2);
    held = count;
    `CMP({dma_req, match_out, irq_flags}, 12'hF44)
    repeat (5) @(posedge mclk);
    #1 `CMP(count, held)
    `CMP(running, 1'b0)
    $display("test stop actions done");
  endtask
  // external count edges, then both capture channels
  task automatic test_counter_capture;
    match_ctl <= '0;
    mode <= CMT_MODE_CNT_RISE;
    // channel 1: falling edge, no irq; channel 0: rising edge with irq
    cap_ctl <= {3'b010, 3'b101};
    restart;
    cmt_pins_model_i.pulse_count(4);
    `CMP(count, 32'h0000_0004)
    cmt_pins_model_i.edge_cap(0);
    `CMP(cap_val[31:0], 32'h0000_0004)
    cmt_pins_model_i.edge_cap(1);
    cmt_pins_model_i.edge_cap(1);
    `CMP(cap_val[63:32], 32'h0000_0004)
    `CMP(irq_flags[5:4], 2'b01)
    $display("test counter capture done");
  endtask
  // falling-edge and both-edge counting, then synchronous clear
  task automatic test_count_edges;
    mode <= CMT_MODE_CNT_FALL;
    restart;
    cmt_pins_model_i.pulse_count(3);
    `CMP(count, 32'h0000_0003)
    mode <= CMT_MODE_CNT_BOTH;
    restart;
    cmt_pins_model_i.pulse_count(2);
    `CMP(count, 32'h0000_0004)
    @(posedge mclk) cnt_reset <= 1'b1;
    @(posedge mclk) cnt_reset <= 1'b0;
    #1 `CMP({count, pre_count}, 64'h0)
    $display("test count edges done");
  endtask
  initial begin
    test_prescale;
    test_reset_match;
    test_stop_actions;
    test_counter_capture;
    test_count_edges;
    complete_run;
  end
endmodule
